//--- rtl/ssh_pkg.sv
// Functional notes
// - data bytes follow header, count from header
// - every data unit is eight bits
// - msb first after reset, lsb on request
// - lsb first reverses serial header and each data byte; two-wire stays msb first
// - select clear: read data on shared line
// - select set: read data on output pin
// - answer address 110110 plus strap bit
// - start is sda fall with scl high
// - seven address bits then direction bit
// - acknowledge own address on ninth clock
// - stop is sda rise, releases transaction
// - sda changes only while scl low
// - header: direction, count, 13-bit address
// - chip select low picks serial peripheral
// - address steps up lsb, down msb
// - short counts may stall, streaming may not
package ssh_pkg;
  localparam int          ADDR_W      = 13;
  localparam int          BYTE_W      = 8;
  localparam logic [4:0]  HDR_LAST    = 5'h0f;
  localparam logic [4:0]  HDR_DONE    = 5'h10;
  localparam logic [2:0]  BIT_LAST    = 3'h7;
  localparam logic [1:0]  CNT_STREAM  = 2'h3;
  localparam logic [5:0]  I2C_ADDR_HI = 6'h36;
  localparam logic [3:0]  I2C_BYTE    = 4'h8;
  localparam logic [12:0] ADDR_RST    = 13'h0000;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  // pin synchroniser after reset: chip select, clock and data idle high
  localparam logic [8:0]  PIN_IDLE    = 9'h1c0;

  typedef enum logic [6:0] {
    I_IDLE = 7'h01,
    I_ADDR = 7'h02,
    I_AACK = 7'h04,
    I_WR   = 7'h08,
    I_WACK = 7'h10,
    I_RD   = 7'h20,
    I_RACK = 7'h40
  } ssh_i2c_t;

  function automatic logic [15:0] ssh_rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) r[i] = v[15-i];
    return r;
  endfunction : ssh_rev16

  function automatic logic [7:0] ssh_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) r[i] = v[7-i];
    return r;
  endfunction : ssh_rev8
endpackage : ssh_pkg

//--- rtl/ssh_port.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module ssh_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= RST;
      q        <= RST;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : ssh_sync

////////////////////////////////////////////////////////////////////////////////
module ssh_port (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       sclk,
  input  wire logic                       cs_n,
  input  wire logic                       sdio_i,
  output logic                            sdio_o,
  output logic                            sdio_oe,
  input  wire logic                       sdo_i,
  output logic                            sdo_o,
  output logic                            sdo_oe,
  input  wire logic                       scl_i,
  input  wire logic                       sda_i,
  output logic                            sda_o,
  output logic                            sda_oe,
  input  wire logic                       lsb_first,
  input  wire logic                       sdo_active,
  output logic [ssh_pkg::ADDR_W-1:0]      reg_addr,
  output logic [ssh_pkg::BYTE_W-1:0]      reg_wdata,
  output logic                            reg_wr,
  output logic                            reg_rd,
  input  wire logic [ssh_pkg::BYTE_W-1:0] reg_rdata
);
  import ssh_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // serial peripheral side, on the link clock
  logic              kill_reg;
  logic              spi_arst;
  logic              lsb_s, act_s;
  logic [4:0]        hdr_cnt_reg, hdr_cnt_next;
  logic [15:0]       hdr_sh_reg, hdr_sh_next;
  logic [2:0]        bit_cnt_reg, bit_cnt_next;
  logic [7:0]        rx_sh_reg, rx_sh_next;
  logic [12:0]       addr_reg, addr_next;
  logic              rw_reg, rw_next;
  logic [1:0]        code_reg, code_next;
  logic [1:0]        left_reg, left_next;
  logic              done_reg, done_next;
  logic              wr_tgl_reg, wr_tgl_next;
  logic [12:0]       wr_addr_reg, wr_addr_next;
  logic [7:0]        wr_data_reg, wr_data_next;
  logic              rd_tgl_reg, rd_tgl_next;
  logic [12:0]       rd_addr_reg, rd_addr_next;
  logic [7:0]        rd_word_reg;

  // a rising chip select only reaches this domain through the clk side
  assign spi_arst = reset | kill_reg;

  ssh_sync #(.W(2)) u_cfg_sync (  // clears to msb first, 3-wire
    .clk   (sclk),
    .reset (spi_arst),
    .d     ({lsb_first, sdo_active}),
    .q     ({lsb_s, act_s})
  );

  always_comb begin
    logic [15:0] h;
    logic [12:0] step;
    h            = 16'h0000;
    step         = lsb_s ? addr_reg + 13'h0001 : addr_reg - 13'h0001;
    hdr_cnt_next = hdr_cnt_reg;
    hdr_sh_next  = hdr_sh_reg;
    bit_cnt_next = bit_cnt_reg;
    rx_sh_next   = rx_sh_reg;
    addr_next    = addr_reg;
    rw_next      = rw_reg;
    code_next    = code_reg;
    left_next    = left_reg;
    done_next    = done_reg;
    wr_tgl_next  = wr_tgl_reg;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    rd_tgl_next  = rd_tgl_reg;
    rd_addr_next = rd_addr_reg;
    if (!done_reg && !cs_n) begin
      if (hdr_cnt_reg != HDR_DONE) begin
        h            = {hdr_sh_reg[14:0], sdio_i};
        hdr_sh_next  = h;
        hdr_cnt_next = hdr_cnt_reg + 5'h01;
        if (hdr_cnt_reg == HDR_LAST) begin
          if (lsb_s) h = ssh_rev16(h);
          rw_next   = h[15];
          code_next = h[14:13];
          left_next = h[14:13];
          addr_next = h[12:0];
          if (h[15]) begin
            rd_tgl_next  = ~rd_tgl_reg;
            rd_addr_next = h[12:0];
          end
        end
      end else begin
        rx_sh_next   = {rx_sh_reg[6:0], sdio_i};
        bit_cnt_next = bit_cnt_reg + 3'h1;
        // fetch the next byte while this one shifts; its first bit leaves at the
        // fall after this byte's last rise, far too soon to fetch it only then
        if (bit_cnt_reg == 3'h0 && rw_reg && !(code_reg != CNT_STREAM && left_reg == 2'h0)) begin
          rd_tgl_next  = ~rd_tgl_reg;
          rd_addr_next = step;
        end
        if (bit_cnt_reg == BIT_LAST) begin
          addr_next = step;
          if (!rw_reg) begin
            wr_tgl_next  = ~wr_tgl_reg;
            wr_addr_next = addr_reg;
            wr_data_next = lsb_s ? ssh_rev8(rx_sh_next) : rx_sh_next;
          end
          if (code_reg != CNT_STREAM) begin
            if (left_reg == 2'h0) done_next = 1'b1;
            else left_next = left_reg - 2'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge sclk or posedge spi_arst) begin
    if (spi_arst) begin
      hdr_cnt_reg <= 5'h00;
      hdr_sh_reg  <= 16'h0000;
      bit_cnt_reg <= 3'h0;
      rx_sh_reg   <= BYTE_RST;
      addr_reg    <= ADDR_RST;
      rw_reg      <= 1'b0;
      code_reg    <= 2'h0;
      left_reg    <= 2'h0;
      done_reg    <= 1'b0;
    end else begin
      hdr_cnt_reg <= hdr_cnt_next;
      hdr_sh_reg  <= hdr_sh_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_sh_reg   <= rx_sh_next;
      addr_reg    <= addr_next;
      rw_reg      <= rw_next;
      code_reg    <= code_next;
      left_reg    <= left_next;
      done_reg    <= done_next;
    end
  end

  // handshake side survives a kill: clearing a toggle would fake a request
  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      wr_tgl_reg  <= 1'b0;
      wr_addr_reg <= ADDR_RST;
      wr_data_reg <= BYTE_RST;
      rd_tgl_reg  <= 1'b0;
      rd_addr_reg <= ADDR_RST;
    end else begin
      wr_tgl_reg  <= wr_tgl_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
      rd_tgl_reg  <= rd_tgl_next;
      rd_addr_reg <= rd_addr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read shifter on the falling edge, so each bit is settled before the rise
  logic [7:0] tx_sh_reg, tx_sh_next;
  logic       sdio_o_next, sdio_oe_next, sdo_o_next, sdo_oe_next;

  always_comb begin
    logic [7:0] w;
    logic       b, en;
    w  = lsb_s ? ssh_rev8(rd_word_reg) : rd_word_reg;
    b  = 1'b0;
    en = rw_reg && (hdr_cnt_reg == HDR_DONE) && !done_reg && !cs_n;
    tx_sh_next = tx_sh_reg;
    if (en) begin
      if (bit_cnt_reg == 3'h0) begin
        b          = w[7];
        tx_sh_next = {w[6:0], 1'b0};
      end else begin
        b          = tx_sh_reg[7];
        tx_sh_next = {tx_sh_reg[6:0], 1'b0};
      end
    end
    sdio_o_next  = b;
    sdio_oe_next = en & ~act_s;
    sdo_o_next   = b;
    sdo_oe_next  = en & act_s;
  end

  always_ff @(negedge sclk or posedge spi_arst) begin
    if (spi_arst) begin
      tx_sh_reg <= BYTE_RST;
      sdio_o    <= 1'b0;
      sdio_oe   <= 1'b0;
      sdo_o     <= 1'b0;
      sdo_oe    <= 1'b0;
    end else begin
      tx_sh_reg <= tx_sh_next;
      sdio_o    <= sdio_o_next;
      sdio_oe   <= sdio_oe_next;
      sdo_o     <= sdo_o_next;
      sdo_oe    <= sdo_oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // crossings into the system clock; word fields stay still while toggles settle
  logic cs_s, scl_s, sda_s, strap_s, wr_s, rd_s, bound_s, stream_s, done_s;
  logic cs_p_reg, scl_p_reg, sda_p_reg, wr_p_reg, rd_p_reg;
  logic kill_next;

  // starts at the idle pin levels, so no false edge or kill follows reset
  ssh_sync #(.W(9), .RST(PIN_IDLE)) u_pin_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({cs_n, scl_i, sda_i, sdo_i, wr_tgl_reg, rd_tgl_reg,
             (hdr_cnt_reg == HDR_DONE) && (bit_cnt_reg == 3'h0),
             code_reg == CNT_STREAM, done_reg}),
    .q     ({cs_s, scl_s, sda_s, strap_s, wr_s, rd_s, bound_s, stream_s, done_s})
  );

  // stalls are only legal on a byte boundary of a short transfer
  assign kill_next = cs_s && !cs_p_reg && (stream_s || !bound_s || done_s);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cs_p_reg  <= 1'b1;
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
      wr_p_reg  <= 1'b0;
      rd_p_reg  <= 1'b0;
      kill_reg  <= 1'b0;
    end else begin
      cs_p_reg  <= cs_s;
      scl_p_reg <= scl_s;
      sda_p_reg <= sda_s;
      wr_p_reg  <= wr_s;
      rd_p_reg  <= rd_s;
      kill_reg  <= kill_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-wire slave, oversampled on the system clock
  ssh_i2c_t  ist_reg, ist_next;
  logic [3:0] icnt_reg, icnt_next;
  logic [7:0] ish_reg, ish_next;
  logic [7:0] iptr_reg, iptr_next;
  logic       ifirst_reg, ifirst_next;
  logic       irw_reg, irw_next;
  logic       icont_reg, icont_next;
  logic       sda_oe_next;
  logic       i_wr, i_rd;
  logic       scl_rise, scl_fall, i_start, i_stop;

  assign scl_rise = scl_s & ~scl_p_reg;
  assign scl_fall = ~scl_s & scl_p_reg;
  assign i_start  = cs_s & scl_s & scl_p_reg & sda_p_reg & ~sda_s;
  assign i_stop   = cs_s & scl_s & scl_p_reg & ~sda_p_reg & sda_s;

  always_comb begin
    ist_next    = ist_reg;
    icnt_next   = icnt_reg;
    ish_next    = ish_reg;
    iptr_next   = iptr_reg;
    ifirst_next = ifirst_reg;
    irw_next    = irw_reg;
    icont_next  = icont_reg;
    sda_oe_next = sda_oe;
    i_wr        = 1'b0;
    i_rd        = 1'b0;
    if (!cs_s || i_stop) begin
      ist_next    = I_IDLE;
      sda_oe_next = 1'b0;
    end else if (i_start) begin
      ist_next    = I_ADDR;
      icnt_next   = 4'h0;
      sda_oe_next = 1'b0;
    end else begin
      case (ist_reg)
        I_IDLE: ist_next = I_IDLE;
        I_ADDR, I_WR: begin
          if (scl_rise) begin
            ish_next  = {ish_reg[6:0], sda_s};
            icnt_next = icnt_reg + 4'h1;
          end else if (scl_fall && icnt_reg == I2C_BYTE) begin
            if (ist_reg == I_WR) begin
              sda_oe_next = 1'b1;
              ist_next    = I_WACK;
              ifirst_next = 1'b0;
              if (ifirst_reg) iptr_next = ish_reg;
              else begin
                i_wr      = 1'b1;
                iptr_next = iptr_reg + 8'h01;
              end
            end else if (ish_reg[7:1] == {I2C_ADDR_HI, strap_s}) begin
              sda_oe_next = 1'b1;
              irw_next    = ish_reg[0];
              ist_next    = I_AACK;
              i_rd        = ish_reg[0];
            end else begin
              ist_next = I_IDLE;
            end
          end
        end
        I_AACK, I_WACK: begin
          if (scl_fall) begin
            icnt_next = 4'h0;
            if (ist_reg == I_AACK && irw_reg) begin
              ist_next    = I_RD;
              ish_next    = rd_word_reg;
              sda_oe_next = ~rd_word_reg[7];
            end else begin
              ist_next    = I_WR;
              ifirst_next = (ist_reg == I_AACK);
              sda_oe_next = 1'b0;
            end
          end
        end
        I_RD: begin
          if (scl_rise) icnt_next = icnt_reg + 4'h1;
          else if (scl_fall) begin
            if (icnt_reg == I2C_BYTE) begin
              sda_oe_next = 1'b0;
              ist_next    = I_RACK;
              iptr_next   = iptr_reg + 8'h01;
            end else begin
              sda_oe_next = ~ish_reg[3'h7 - icnt_reg[2:0]];
            end
          end
        end
        I_RACK: begin
          if (scl_rise) begin
            icont_next = ~sda_s;
            i_rd       = ~sda_s;
          end else if (scl_fall) begin
            icnt_next = 4'h0;
            if (icont_reg) begin
              ist_next    = I_RD;
              ish_next    = rd_word_reg;
              sda_oe_next = ~rd_word_reg[7];
            end else ist_next = I_IDLE;
          end
        end
        default: begin
          ist_next    = I_IDLE;
          sda_oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ist_reg    <= I_IDLE;
      icnt_reg   <= 4'h0;
      ish_reg    <= BYTE_RST;
      iptr_reg   <= BYTE_RST;
      ifirst_reg <= 1'b0;
      irw_reg    <= 1'b0;
      icont_reg  <= 1'b0;
      sda_oe     <= 1'b0;
      sda_o      <= 1'b0;
    end else begin
      ist_reg    <= ist_next;
      icnt_reg   <= icnt_next;
      ish_reg    <= ish_next;
      iptr_reg   <= iptr_next;
      ifirst_reg <= ifirst_next;
      irw_reg    <= irw_next;
      icont_reg  <= icont_next;
      sda_oe     <= sda_oe_next;
      sda_o      <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port; the two protocols never run at once, serial peripheral wins
  logic        spi_wr_ev, spi_rd_ev, rd_cap_reg;
  logic [12:0] reg_addr_next;
  logic [7:0]  reg_wdata_next, rd_word_next;

  assign spi_wr_ev = wr_s ^ wr_p_reg;
  assign spi_rd_ev = rd_s ^ rd_p_reg;

  always_comb begin
    reg_addr_next  = reg_addr;
    reg_wdata_next = reg_wdata;
    rd_word_next   = rd_cap_reg ? reg_rdata : rd_word_reg;
    if (spi_wr_ev) begin
      reg_addr_next  = wr_addr_reg;
      reg_wdata_next = wr_data_reg;
    end else if (spi_rd_ev) reg_addr_next = rd_addr_reg;
    else if (i_wr) begin
      reg_addr_next  = {5'h00, iptr_reg};
      reg_wdata_next = ish_reg;
    end else if (i_rd) reg_addr_next = {5'h00, iptr_reg};
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_addr    <= ADDR_RST;
      reg_wdata   <= BYTE_RST;
      reg_wr      <= 1'b0;
      reg_rd      <= 1'b0;
      rd_cap_reg  <= 1'b0;
      rd_word_reg <= BYTE_RST;
    end else begin
      reg_addr    <= reg_addr_next;
      reg_wdata   <= reg_wdata_next;
      reg_wr      <= spi_wr_ev | i_wr;
      reg_rd      <= (spi_rd_ev & ~spi_wr_ev) | (i_rd & ~spi_wr_ev);
      rd_cap_reg  <= reg_rd;
      rd_word_reg <= rd_word_next;
    end
  end
endmodule : ssh_port

//--- testbench/ssh_port_asserts.sv
`timescale 1ns/1ps
////////////////////////////////////////
module ssh_port_asserts (
  input wire logic                       clk,
  input wire logic                       reset,
  input wire logic                       cs_n,
  input wire logic                       scl_i,
  input wire logic                       sda_o,
  input wire logic                       sda_oe,
  input wire logic                       sdio_oe,
  input wire logic                       sdo_oe,
  input wire logic                       sdo_active,
  input wire logic [ssh_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ssh_pkg::BYTE_W-1:0] reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd
);
  import ssh_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_wr_pulse; reg_wr |=> !reg_wr; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  property p_addr_hold; $changed(reg_addr) |-> reg_wr || reg_rd; endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved idle");
  property p_wdata_hold; $changed(reg_wdata) |-> reg_wr; endproperty
  a_wdata_hold: assert property (p_wdata_hold) else $error("data moved idle");
  property p_sda_low; sda_oe |-> !sda_o; endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda driven high");
  // the data line may only move while the clock is low on both sampled edges
  property p_sda_scl; $changed(sda_oe) |-> !scl_i && !$past(scl_i); endproperty
  a_sda_scl: assert property (p_sda_scl) else $error("sda moved, scl high");
  property p_ack_len; $rose(sda_oe) |-> sda_oe[*8]; endproperty
  a_ack_len: assert property (p_ack_len) else $error("sda pull too short");
  property p_i2c_only; sda_oe |-> cs_n; endproperty
  a_i2c_only: assert property (p_i2c_only) else $error("two-wire answer, cs low");
  property p_three; sdio_oe |-> !sdo_active && !sdo_oe; endproperty
  a_three: assert property (p_three) else $error("shared line in 4-wire");
  property p_four; sdo_oe |-> sdo_active; endproperty
  a_four: assert property (p_four) else $error("output pin in 3-wire");
  c_wr: cover property (reg_wr);
  c_four: cover property (sdo_oe);
  c_ack: cover property ($rose(sda_oe));
endmodule : ssh_port_asserts
bind ssh_port ssh_port_asserts chk (.clk, .reset, .cs_n, .scl_i, .sda_o, .sda_oe, .sdio_oe,
  .sdo_oe, .sdo_active, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

//--- testbench/ssh_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////
module ssh_host_model (
  input  wire logic sdio_o,
  input  wire logic sdio_oe,
  input  wire logic sdo_o,
  input  wire logic sdo_oe,
  input  wire logic sda_oe,
  output logic      sclk,
  output logic      cs_n,
  output logic      sdio_i,
  output logic      sdo_i,
  output logic      scl_i,
  output logic      sda_i
);
  logic       drv, on, strap, sda_h, four, dead;
  logic [7:0] wbuf [4];
  logic [7:0] rbuf [4];
  int         nbit, cut_at;
  // a released line must not keep its last level, so it shows the inverse
  assign sdio_i = sdio_oe ? sdio_o : (on ? drv : !drv);
  assign sdo_i  = sdo_oe ? sdo_o : strap;
  assign sda_i  = sda_h && !sda_oe; // pull-up with wired low
  initial begin
    {sclk, drv, strap, four, dead} = '0;
    {cs_n, on, sda_h, scl_i} = '1;
    cut_at = 0;
  end
  task automatic sbit(input logic b, input int hold, output logic q);
    if (!dead) begin
      drv = b;
      #16 sclk = 1'b1; // device samples on this edge
      q = four ? sdo_i : sdio_i;
      #(hold) sclk = 1'b0;
      nbit++;
      dead = (nbit == cut_at);
    end
  endtask : sbit
  task automatic spi(input logic rw, input logic [1:0] cnt, input logic [12:0] a,
                     input logic lsb, input int nb, input logic stall);
    logic [15:0] h;
    logic        q;
    h = {rw, cnt, a};
    nbit = 0;
    dead = 1'b0;
    #3 cs_n = 1'b0;
    #20;
    // long hold after the last header bit gives the device time to fetch
    for (int i = 0; i < 16; i++) sbit(lsb ? h[i] : h[15-i], (rw && i == 15) ? 240 : 16, q);
    on = !rw;
    for (int k = 0; k < nb; k++) begin
      for (int i = 0; i < 8; i++) begin
        sbit(lsb ? wbuf[k][i] : wbuf[k][7-i], 16, q);
        rbuf[k][lsb ? i : 7-i] = q;
      end
      if (stall && !dead) begin
        cs_n = 1'b1; // stall on a byte boundary
        #200 cs_n = 1'b0;
      end
    end
    #40 cs_n = 1'b1;
    on = 1'b1;
    #200;
  endtask : spi
  task automatic ibit(input logic b, output logic q);
    #200 sda_h = b;
    #200 scl_i = 1'b1;
    #200 q = sda_i;
    #200 scl_i = 1'b0;
  endtask : ibit
  task automatic istart();
    #200 sda_h = 1'b1;
    #200 scl_i = 1'b1;
    #400 sda_h = 1'b0;
    #400 scl_i = 1'b0;
  endtask : istart
  task automatic istop();
    #200 sda_h = 1'b0;
    #200 scl_i = 1'b1;
    #400 sda_h = 1'b1;
    #400;
  endtask : istop
  task automatic ibyte(input logic [7:0] tx, input logic atx, output logic [7:0] rx,
                       output logic arx);
    for (int i = 7; i >= 0; i--) ibit(tx[i], rx[i]);
    ibit(atx, arx);
  endtask : ibyte
endmodule : ssh_host_model

//--- testbench/ssh_port_test.sv
`timescale 1ns/1ps
////////////////////////////////////////
module ssh_port_test;
  import ssh_pkg::*;
  localparam logic [5:0] OWN_HI = 6'h36;
  logic              clk, reset, lsb_first, sdo_active, reg_wr, reg_rd, ak;
  logic              sclk, cs_n, sdio_i, sdio_o, sdio_oe, sdo_i, sdo_o, sdo_oe;
  logic              scl_i, sda_i, sda_o, sda_oe;
  logic [ADDR_W-1:0] reg_addr;
  logic [BYTE_W-1:0] reg_wdata, reg_rdata;
  logic [7:0]        mem [256];
  logic [12:0]       wq_a [$];
  logic [7:0]        wq_d [$];
  logic [7:0]        rx;
  int                error_cnt, cmp_count, cyc, seed;

  ssh_port uut (.clk, .reset, .sclk, .cs_n, .sdio_i, .sdio_o, .sdio_oe, .sdo_i, .sdo_o,
    .sdo_oe, .scl_i, .sda_i, .sda_o, .sda_oe, .lsb_first, .sdo_active, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  ssh_host_model host (.sdio_o, .sdio_oe, .sdo_o, .sdo_oe, .sda_oe, .sclk, .cs_n,
    .sdio_i, .sdo_i, .scl_i, .sda_i);

  initial begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  // register file stand-in: read data settles long before the capture edge
  always @(negedge clk) begin
    reg_rdata <= mem[reg_addr[7:0]];
    if (reg_wr) begin
      wq_a.push_back(reg_addr);
      wq_d.push_back(reg_wdata);
      mem[reg_addr[7:0]] = reg_wdata;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      final_report();
    end
  end
  ////////////////////////////////////////
  task automatic final_report();
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask : check
  function automatic logic [12:0] step(input logic [12:0] a, input int k, input logic l);
    return l ? a + 13'(k) : a - 13'(k);
  endfunction : step
  task automatic spi_rt(input logic l, input logic f, input logic [1:0] c, input int nb,
                        input logic stall);
    logic [12:0] a;
    int          n;
    a = 13'(8'h20 + 8'($random(seed) & 8'h7f));
    n = int'(c) + 1;
    @(negedge clk);
    lsb_first = l;
    sdo_active = f;
    host.four = f;
    for (int k = 0; k < 4; k++) host.wbuf[k] = 8'($random(seed));
    wq_a.delete();
    wq_d.delete();
    host.spi(1'b0, c, a, l, nb, stall);
    repeat (8) @(negedge clk);
    check(16'(wq_a.size()), 16'(n), "write count");
    for (int k = 0; k < n; k++) begin
      check(16'(wq_a[k]), 16'(step(a, k, l)), "write addr");
      check(16'(wq_d[k]), 16'(host.wbuf[k]), "write data");
    end
    host.spi(1'b1, c, a, l, n, 1'b0);
    for (int k = 0; k < n; k++) check(16'(host.rbuf[k]), 16'(host.wbuf[k]), "read");
  endtask : spi_rt
  task automatic i2c_addr(input logic rw, input logic [6:0] ad, input logic hit);
    host.istart();
    host.ibyte({ad, rw}, 1'b1, rx, ak);
    check(16'(ak), 16'(!hit), "address ack");
  endtask : i2c_addr
  ////////////////////////////////////////
  initial begin
    logic [7:0] p, d0, d1;
    seed = 32'ha9fe;
    reset = 1'b1;
    lsb_first = 1'b0;
    sdo_active = 1'b0;
    reg_rdata = '0;
    for (int i = 0; i < 256; i++) mem[i] = 8'($random(seed));
    repeat (16) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    for (int l = 0; l < 2; l++) begin
      for (int f = 0; f < 2; f++) begin
        for (int c = 0; c < 4; c++) spi_rt(l[0], f[0], c[1:0], c + 1, 1'b0);
      end
    end
    spi_rt(1'b0, 1'b0, 2'h1, 2, 1'b1);
    spi_rt(1'b1, 1'b1, 2'h0, 3, 1'b0);
    host.cut_at = 27;
    wq_a.delete();
    host.spi(1'b0, 2'h3, 13'h0040, 1'b1, 4, 1'b0);
    host.cut_at = 0;
    repeat (8) @(negedge clk);
    check(16'(wq_a.size()), 16'h0001, "cut count");
    spi_rt(1'b0, 1'b0, 2'h3, 4, 1'b0);
    lsb_first = 1'b1; // two-wire bytes stay msb first regardless
    for (int s = 0; s < 2; s++) begin
      host.strap = s[0];
      p = 8'h20 + 8'($random(seed) & 8'h3f);
      d0 = 8'($random(seed));
      d1 = 8'($random(seed));
      wq_a.delete();
      wq_d.delete();
      i2c_addr(1'b0, {OWN_HI, s[0]}, 1'b1);
      host.ibyte(p, 1'b1, rx, ak);
      check(16'(ak), 16'h0000, "pointer ack");
      host.ibyte(d0, 1'b1, rx, ak);
      host.ibyte(d1, 1'b1, rx, ak);
      host.istop();
      @(negedge clk);
      check(16'(wq_a.size()), 16'h0002, "i2c writes");
      check(16'(wq_a[0]), 16'(p), "i2c addr 0");
      check(16'(wq_a[1]), 16'(p) + 16'h0001, "i2c addr 1");
      check(16'(wq_d[0]), 16'(d0), "i2c data 0");
      check(16'(wq_d[1]), 16'(d1), "i2c data 1");
      i2c_addr(1'b0, {OWN_HI, s[0]}, 1'b1);
      host.ibyte(p, 1'b1, rx, ak);
      i2c_addr(1'b1, {OWN_HI, s[0]}, 1'b1);
      host.ibyte(8'hff, 1'b0, rx, ak);
      check(16'(rx), 16'(d0), "i2c read 0");
      host.ibyte(8'hff, 1'b1, rx, ak);
      check(16'(rx), 16'(d1), "i2c read 1");
      host.istop();
      i2c_addr(1'b0, {OWN_HI, !s[0]}, 1'b0);
      host.istop();
    end
    host.cs_n = 1'b0;
    i2c_addr(1'b0, {OWN_HI, host.strap}, 1'b0);
    host.istop();
    host.cs_n = 1'b1;
    repeat (10) @(negedge clk);
    final_report();
  end
endmodule : ssh_port_test
